// ===== design/adc_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_conversion_sequencer #(
   parameter int unsigned CONVERSION_START_N_CYCLES = `ADC_CONVERSION_START_N_CYCLES,
   parameter int unsigned START_LAT   = `ADC_START_LAT,
   parameter int unsigned RDY_EARLY   = `ADC_RDY_EARLY
) (
   // clock and reset
   input  wire logic                      ref_clk_in,
   input  wire logic                      rst_n_in,
   // pins from host
   input  wire logic                      mclk_pin_in,
   input  wire logic                      conversion_start_n_in,
   input  wire logic                      chip_select_n_in,
   input  wire logic                      polarity_select_in,
   // serial port and filter
   input  wire logic                      port_drained_in,
   input  wire adc_seq_pkg::sample_word_t raw_sample_in,
   // results and status
   output logic                           data_ready_n_out,
   output adc_seq_pkg::sample_word_t      port_word_out,
   output logic                           word_loaded_out,
   output logic                           converting_out,
   output adc_seq_pkg::clk_source_t       clock_source_out
);
   import adc_seq_pkg::*;

   mclk_tick_if tick_if ();

   mclk_source_select u_clk_sel (
      .ref_clk_in  (ref_clk_in),
      .rst_n_in    (rst_n_in),
      .mclk_pin_in (mclk_pin_in),
      .tick_if     (tick_if.src)
   );

   seq_state_t              state_q;
   logic [`ADC_CNT_BITS-1:0] cnt_q;
   logic                    unread_q;
   logic                    last_cycle;
   logic                    early_cycle;
   logic                    arm_done;
   logic                    tick;

   assign tick        = tick_if.tick;
   assign last_cycle  = (state_q == SEQ_CONVERT)
                     && (cnt_q == CONVERSION_START_N_CYCLES[`ADC_CNT_BITS-1:0] - 1'b1);
   assign early_cycle = (state_q == SEQ_CONVERT)
                     && (cnt_q == CONVERSION_START_N_CYCLES[`ADC_CNT_BITS-1:0]
                               - RDY_EARLY[`ADC_CNT_BITS-1:0] - 1'b1);
   assign arm_done    = (state_q == SEQ_ARM)
                     && (cnt_q == START_LAT[`ADC_CNT_BITS-1:0] - 1'b1);

   function automatic sample_word_t encode(input sample_word_t raw,
                                           input logic bipolar);
      encode = bipolar ? (raw ^ `ADC_SIGN_FLIP) : raw;
   endfunction

   // reset clears the counter, so all parts released together stay aligned
   // start is only looked at on ticks, hence a lag of up to one tick period, 16 clocks on the internal oscillator
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= SEQ_IDLE;
      end else if (tick) begin
         case (state_q)
            SEQ_IDLE: begin
               if (!conversion_start_n_in) begin
                  state_q <= SEQ_ARM;
               end
            end
            SEQ_ARM: begin
               if (arm_done) begin
                  state_q <= SEQ_CONVERT;
               end
            end
            SEQ_CONVERT: begin
               if (last_cycle && conversion_start_n_in) begin
                  state_q <= SEQ_IDLE;
               end
            end
            default: begin
               state_q <= SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
      end else if (tick) begin
         // the tick that takes start is the first of the start latency
         if ((state_q == SEQ_IDLE && conversion_start_n_in)
             || arm_done || last_cycle) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_word_out <= '0;
      end else if (tick && last_cycle) begin
         port_word_out <= encode(raw_sample_in, polarity_select_in);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         word_loaded_out <= 1'b0;
      end else begin
         word_loaded_out <= tick && last_cycle;
      end
   end

   // a new load wins over a drain seen in the same cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_ready_n_out <= 1'b1;
      end else if (tick && last_cycle) begin
         data_ready_n_out <= 1'b0;
      end else if (port_drained_in) begin
         data_ready_n_out <= 1'b1;
      end else if (tick && early_cycle && unread_q && !chip_select_n_in) begin
         data_ready_n_out <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         unread_q <= 1'b0;
      end else if (tick && last_cycle) begin
         unread_q <= 1'b1;
      end else if (port_drained_in) begin
         unread_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         converting_out <= 1'b0;
      end else begin
         converting_out <= (state_q == SEQ_CONVERT);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clock_source_out <= CLK_STOPPED;
      end else begin
         clock_source_out <= tick_if.source;
      end
   end
endmodule // adc_conversion_sequencer
`default_nettype wire

// ===== design/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define ADC_WORD_BITS      16
`define ADC_CONVERSION_START_N_CYCLES    80
`define ADC_START_LAT      2
`define ADC_RDY_EARLY      2
`define ADC_CNT_BITS       7
`define ADC_SIGN_FLIP      16'h8000
`define ADC_REF_PERIOD_NS  4
`define ADC_OSC_PERIOD_NS  64
`define ADC_OSC_DIV        (`ADC_OSC_PERIOD_NS / `ADC_REF_PERIOD_NS)
`define ADC_EXT_TIMEOUT_NS 256
`define ADC_EXT_TIMEOUT    (`ADC_EXT_TIMEOUT_NS / `ADC_REF_PERIOD_NS)
`define ADC_TMR_BITS       8

`endif

// ===== design/adc_seq_pkg.sv
package adc_seq_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_ARM,
      SEQ_CONVERT
   } seq_state_t;

   typedef enum logic [1:0] {
      CLK_STOPPED,
      CLK_INTERNAL,
      CLK_EXTERNAL
   } clk_source_t;

   typedef logic [15:0] sample_word_t;
endpackage

// ===== design/mclk_source_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module mclk_source_select #(
   parameter int unsigned EXT_TIMEOUT = `ADC_EXT_TIMEOUT,
   parameter int unsigned OSC_DIV     = `ADC_OSC_DIV
) (
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   // master clock pin
   input  wire logic mclk_pin_in,
   // tick carrier
   mclk_tick_if.src  tick_if
);
   import adc_seq_pkg::*;

   logic                     pin_q;
   logic                     seen_q;
   logic                     moved_q;
   logic [`ADC_TMR_BITS-1:0] still_q;
   logic [`ADC_TMR_BITS-1:0] osc_q;
   logic                     pin_fall;
   logic                     pin_edge;

   // no compare until the pin has been seen once: its idle level is unknown
   assign pin_fall = seen_q & pin_q & ~mclk_pin_in;
   assign pin_edge = seen_q & (pin_q ^ mclk_pin_in);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_q  <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         pin_q  <= mclk_pin_in;
         seen_q <= 1'b1;
      end
   end

   // only a real pin edge since reset may select the external source
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         moved_q <= 1'b0;
      end else if (pin_edge) begin
         moved_q <= 1'b1;
      end
   end

   // time since the pin last moved decides between external and static
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         still_q <= '0;
      end else if (pin_edge) begin
         still_q <= '0;
      end else if (still_q != EXT_TIMEOUT[`ADC_TMR_BITS-1:0]) begin
         still_q <= still_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_if.source <= CLK_STOPPED;
      end else if (moved_q
                   && still_q != EXT_TIMEOUT[`ADC_TMR_BITS-1:0]) begin
         tick_if.source <= CLK_EXTERNAL;
      end else if (pin_q
                   || still_q != EXT_TIMEOUT[`ADC_TMR_BITS-1:0]) begin
         tick_if.source <= CLK_STOPPED;
      end else begin
         tick_if.source <= CLK_INTERNAL;
      end
   end

   // oscillator only divides while selected, so it costs nothing otherwise
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_q <= '0;
      end else if (tick_if.source != CLK_INTERNAL) begin
         osc_q <= '0;
      end else if (osc_q == OSC_DIV[`ADC_TMR_BITS-1:0] - 1'b1) begin
         osc_q <= '0;
      end else begin
         osc_q <= osc_q + 1'b1;
      end
   end

   // one tick per falling master clock edge, or one per OSC_DIV clocks on the internal oscillator, keeps parts in lockstep
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_if.tick <= 1'b0;
      end else if (tick_if.source == CLK_INTERNAL) begin
         tick_if.tick <= (osc_q == OSC_DIV[`ADC_TMR_BITS-1:0] - 1'b1);
      end else begin
         tick_if.tick <= pin_fall;
      end
   end
endmodule // mclk_source_select
`default_nettype wire

// ===== design/mclk_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mclk_tick_if;
   import adc_seq_pkg::*;
   logic        tick;
   clk_source_t source;
   modport src (output tick, output source);
   modport snk (input tick, input source);
endinterface
`default_nettype wire

// ===== sim/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb_top;
   import adc_seq_pkg::*;
   logic         ref_clk, rst_n, mclk, tog, ph, cs_n, pol, drain_en;
   logic         start_n, drained, rdy_n, loaded, conversion_start_n;
   logic [1:0]   mode;
   logic [31:0]  seed;
   sample_word_t raw, word, exp_w;
   clk_source_t  src;
   int           falls, failures, checks, t0, t1;
   adc_conversion_sequencer adc_conversion_sequencer_inst (
      .ref_clk_in(ref_clk), .rst_n_in(rst_n), .mclk_pin_in(mclk),
      .conversion_start_n_in(start_n), .chip_select_n_in(cs_n),
      .polarity_select_in(pol), .port_drained_in(drained),
      .raw_sample_in(raw), .data_ready_n_out(rdy_n), .port_word_out(word),
      .word_loaded_out(loaded), .converting_out(conversion_start_n),
      .clock_source_out(src));
   host_model host_model_inst (
      .ref_clk_in(ref_clk), .rst_n_in(rst_n), .mode_in(mode),
      .drain_en_in(drain_en), .data_ready_n_in(rdy_n),
      .word_loaded_in(loaded), .conversion_start_n_out(start_n),
      .port_drained_out(drained));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic sample_word_t enc(sample_word_t r, logic p);
      return p ? r ^ 16'h8000 : r;
   endfunction
   task automatic give_verdict();
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_fall(output int t);
      logic p;
      int   i;
      p = rdy_n;
      for (i = 0; i < 1500; i++) begin
         @(negedge ref_clk);
         if (p === 1'b1 && rdy_n === 1'b0) break;
         p = rdy_n;
      end
      if (i == 1500) begin
         failures++;
         give_verdict();
      end
      t = falls;
   endtask
   task automatic wait_conversion_start_n(logic v);
      int i;
      for (i = 0; i < 1500 && conversion_start_n !== v; i++) @(negedge ref_clk);
      if (i == 1500) begin
         failures++;
         give_verdict();
      end
   endtask
   always #2 ref_clk = ~ref_clk;
   // pin toggles every two clocks, a falling edge every four
   always @(posedge ref_clk) begin
      if (tog) begin
         ph <= ~ph;
         if (ph) mclk <= ~mclk;
         if (ph && mclk) falls <= falls + 1;
      end
      if (loaded) begin
         seed <= lfsr(seed);
         raw  <= seed[15:0];
      end
   end
   initial begin
      ref_clk = 0; rst_n = 0; mclk = 1; tog = 0; ph = 0; cs_n = 0; pol = 0;
      drain_en = 0; mode = 0; seed = 32'hd155; raw = 16'hffff; falls = 0;
      failures = 0; checks = 0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (20) @(negedge ref_clk);
      chk("ready", 16'(rdy_n), 16'h0001);
      chk("source", 16'(src), 16'(CLK_STOPPED));
      @(posedge ref_clk) mclk <= 1'b0;
      repeat (100) @(negedge ref_clk);
      chk("source", 16'(src), 16'(CLK_INTERNAL));
      @(posedge ref_clk) tog <= 1'b1;
      repeat (40) @(negedge ref_clk);
      chk("source", 16'(src), 16'(CLK_EXTERNAL));
      for (int p = 0; p < 2; p++) begin
         @(posedge ref_clk) pol <= p[0];
         mode <= 2'h1;
         wait_fall(t0);
         wait_fall(t1);
         chk("period", 16'(t1 - t0), 16'h0050);
         chk("word", word, enc(raw, pol));
      end
      drain_en <= 1'b1;
      wait_fall(t0);
      repeat (2) @(negedge ref_clk);
      chk("drained", 16'(rdy_n), 16'h0001);
      @(posedge ref_clk) drain_en <= 1'b0;
      mode <= 2'h2;
      wait_fall(t0);
      wait_fall(t0);
      wait_fall(t1);
      chk("tied", 16'(t1 - t0), 16'h0052);
      @(posedge ref_clk) mode <= 2'h0;
      wait_conversion_start_n(1'b0);
      @(posedge ref_clk) mode <= 2'h1;
      wait_conversion_start_n(1'b1);
      @(posedge ref_clk) mode <= 2'h0;
      wait_fall(t0);
      chk("single", word, enc(raw, pol));
      repeat (400) @(negedge ref_clk);
      chk("one only", {15'h0000, conversion_start_n, rdy_n}, 16'h0000);
      @(posedge ref_clk) cs_n <= 1'b1;
      exp_w = enc(raw, pol);
      mode <= 2'h1;
      wait_conversion_start_n(1'b1);
      @(posedge ref_clk) mode <= 2'h0;
      wait_conversion_start_n(1'b0);
      chk("held", 16'(rdy_n), 16'h0000);
      chk("next word", word, exp_w);
      @(posedge ref_clk) mode <= 2'h1;
      cs_n <= 1'b0;
      rst_n <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("in reset", {15'h0000, conversion_start_n, rdy_n}, 16'h0001);
      @(posedge ref_clk) rst_n <= 1'b1;
      wait_fall(t0);
      wait_fall(t1);
      chk("period", 16'(t1 - t0), 16'h0050);
      give_verdict();
   end
endmodule // adc_conversion_sequencer_tb_top
bind adc_conversion_sequencer adc_seq_monitor adc_seq_monitor_inst (
   .ref_clk_in, .rst_n_in, .mclk_pin_in, .chip_select_n_in,
   .polarity_select_in, .port_drained_in, .raw_sample_in, .data_ready_n_out,
   .port_word_out, .word_loaded_out, .converting_out, .clock_source_out);
`default_nettype wire

// ===== sim/adc_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor (
   // clock and reset
   input wire logic                      ref_clk_in,
   input wire logic                      rst_n_in,
   // inputs seen
   input wire logic                      mclk_pin_in,
   input wire logic                      chip_select_n_in,
   input wire logic                      polarity_select_in,
   input wire logic                      port_drained_in,
   input wire adc_seq_pkg::sample_word_t raw_sample_in,
   // outputs seen
   input wire logic                      data_ready_n_out,
   input wire adc_seq_pkg::sample_word_t port_word_out,
   input wire logic                      word_loaded_out,
   input wire logic                      converting_out,
   input wire adc_seq_pkg::clk_source_t  clock_source_out
);
   import adc_seq_pkg::*;
   logic       mclk_q;
   logic [7:0] gap_q;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // pin falls between ready falls; saturates so idle gaps stay legal
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mclk_q <= 1'b1;
         gap_q  <= 8'h00;
      end else begin
         mclk_q <= mclk_pin_in;
         if ($fell(data_ready_n_out)) gap_q <= 8'h00;
         else if (mclk_q && !mclk_pin_in && gap_q != 8'hff) gap_q <= gap_q + 8'h01;
      end
   end
   a_reset_idle:
      assert property ($rose(rst_n_in) |-> data_ready_n_out && !converting_out)
         else $error("busy after reset");
   a_fall_on_load:
      assert property ($fell(data_ready_n_out) |-> word_loaded_out && converting_out)
         else $error("ready fell without load");
   a_drain_release:
      assert property (port_drained_in |=> data_ready_n_out || word_loaded_out)
         else $error("ready held after drain");
   a_word_on_load:
      assert property ($changed(port_word_out) |-> word_loaded_out)
         else $error("word changed without load");
   a_word_coding:
      assert property (word_loaded_out |-> port_word_out ==
         ($past(raw_sample_in) ^ {$past(polarity_select_in), 15'h0000}))
         else $error("word coding wrong");
   a_early_rise:
      assert property ($rose(data_ready_n_out) && !$past(port_drained_in) |->
         !$past(chip_select_n_in) ##8 $fell(data_ready_n_out))
         else $error("early rise wrong");
   a_stopped_frozen:
      assert property ((clock_source_out == CLK_STOPPED) [*2] |=> $stable(converting_out))
         else $error("progress while stopped");
   a_conversion_start_n_length:
      assert property ($fell(data_ready_n_out) |-> gap_q >= 8'h50)
         else $error("conversion too short");
endmodule // adc_seq_monitor
`default_nettype wire

// ===== sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   // bench control
   input  wire logic [1:0] mode_in,
   input  wire logic       drain_en_in,
   // device pins
   input  wire logic       data_ready_n_in,
   input  wire logic       word_loaded_in,
   output logic            conversion_start_n_out,
   output logic            port_drained_out
);
   // start only moves on the clock edge so it never straddles a tick
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         conversion_start_n_out <= 1'b1;
      end else begin
         case (mode_in)
            2'h1: conversion_start_n_out <= 1'b0;
            2'h2: conversion_start_n_out <= data_ready_n_in;
            default: conversion_start_n_out <= 1'b1;
         endcase
      end
   end
   // whole word read one cycle after it lands, no bits left behind
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) port_drained_out <= 1'b0;
      else port_drained_out <= drain_en_in && word_loaded_in;
   end
endmodule // host_model
`default_nettype wire
